// [dv/ccr_alu_model.sv]
`timescale 1ns/1ps
// alu stand-in; one sum in four wraps to zero so zero flags move
module ccr_alu_model
(
    // clock
    input wire logic clk,
    // results
    output logic [7:0] result = 8'h00,
    output logic carry = 1'b0
);
    logic [7:0] a;
    logic [7:0] b;
    // fresh operands every machine cycle
    always @(posedge clk)
    begin
        a = 8'($urandom);
        b = ($urandom % 4 == 0) ? -a : 8'($urandom);
        {carry, result} <= {1'b0, a} + {1'b0, b};
    end
endmodule : ccr_alu_model

// [dv/ccr_core_regs_props.sv]
`timescale 1ns/1ps
// port-level checks on the register block
module ccr_core_regs_props
    import ccr_pkg::*;
#(
    parameter logic [11:0] IRQ_VECTOR = 12'hFF0
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // data space
    input wire logic [7:0] DS_ADDR,
    input wire logic DS_WR,
    input wire logic [7:0] DS_WDATA,
    input wire logic [7:0] DS_RDATA,
    input wire logic DS_HIT,
    input wire logic [7:0] ACC,
    // pc, stack and flags
    input wire logic [2:0] PC_SRC,
    input wire logic [11:0] PC_TARGET,
    input wire logic [11:0] PC,
    input wire logic STACK_EMPTY,
    input wire logic FLAG_ZERO_WE,
    input wire logic [7:0] ALU_RESULT,
    input wire logic ZERO,
    input wire logic [2:0] CONTEXT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    // call then an immediate return
    sequence call_ret_s;
        PC_SRC == 3'h4 ##1 PC_SRC == 3'h7;
    endsequence
    chk_hit_decode: assert property (
        DS_HIT == (DS_ADDR inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hFF})) else $error("hit decode");
    chk_miss_zero: assert property (
        !DS_HIT |-> DS_RDATA == 8'h00) else $error("miss read");
    chk_acc_write: assert property (
        DS_WR && DS_ADDR == 8'hFF |=> ACC == $past(DS_WDATA)) else $error("acc write");
    chk_pc_inc: assert property (
        PC_SRC == 3'h1 |=> PC == $past(PC) + 12'h001) else $error("pc inc");
    chk_pc_jump: assert property (
        PC_SRC == 3'h3 |=> PC == $past(PC_TARGET)) else $error("pc jump");
    chk_call_return: assert property (
        call_ret_s |=> PC == $past(PC, 2)) else $error("call return");
    chk_irq_entry: assert property (
        PC_SRC == 3'h5 |=> CONTEXT == 3'h2 && PC == IRQ_VECTOR) else $error("irq entry");
    chk_zero_flag: assert property (
        FLAG_ZERO_WE && PC_SRC < 3'h5 |=> ZERO == ($past(ALU_RESULT) == 8'h00)) else $error("zero");
    chk_empty_ret: assert property (
        PC_SRC == 3'h7 && STACK_EMPTY |=> STACK_EMPTY && PC == $past(PC) + 12'h001) else $error("empty ret");
endmodule : ccr_core_regs_props

// [dv/cpu_context_regs_stack_tb.sv]
`timescale 1ns/1ps
module cpu_context_regs_stack_tb;
    import ccr_pkg::*;
    localparam logic [11:0] IRQ_VECTOR = 12'hFF0;
    localparam logic [11:0] NMI_VECTOR = 12'hFFC;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [7:0] DS_ADDR = 8'h00, DS_WDATA = 8'h00, REL_OFFSET = 8'h00;
    logic DS_WR = 1'b0, FLAG_CARRY_WE = 1'b0, FLAG_ZERO_WE = 1'b0, IRQ_EXIT = 1'b0;
    logic [2:0] PC_SRC = 3'h0;
    logic [11:0] PC_TARGET = 12'h000;
    wire logic [7:0] DS_RDATA, PTR_FIRST, PTR_SECOND, ACC, ALU_RESULT;
    wire logic [11:0] PC;
    wire logic [2:0] CONTEXT;
    wire logic DS_HIT, STACK_EMPTY, CARRY, ZERO, FLAG_CARRY_IN;
    int errors = 0, total_checks = 0, cycles = 0;
    // reference state; flags indexed by one-hot context
    logic [11:0] m_pc = 12'hFFE;
    logic [11:0] stk[$];
    int m_ctx = 4, m_saved = 1, m_reg[256] = '{default: 0};
    bit m_c[8], m_z[8];
    logic [7:0] amap[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
    always #10 CLK = ~CLK;
    ccr_core_regs #(.IRQ_VECTOR(IRQ_VECTOR), .NMI_VECTOR(NMI_VECTOR)) uut (.CLK(CLK), .RST_B(RST_B),
        .DS_ADDR(DS_ADDR), .DS_WR(DS_WR), .DS_WDATA(DS_WDATA), .DS_RDATA(DS_RDATA), .DS_HIT(DS_HIT),
        .PTR_FIRST(PTR_FIRST), .PTR_SECOND(PTR_SECOND), .ACC(ACC), .PC_SRC(PC_SRC), .PC_TARGET(PC_TARGET),
        .REL_OFFSET(REL_OFFSET), .PC(PC), .STACK_EMPTY(STACK_EMPTY), .FLAG_CARRY_WE(FLAG_CARRY_WE),
        .FLAG_CARRY_IN(FLAG_CARRY_IN), .FLAG_ZERO_WE(FLAG_ZERO_WE), .ALU_RESULT(ALU_RESULT),
        .IRQ_EXIT(IRQ_EXIT), .CARRY(CARRY), .ZERO(ZERO), .CONTEXT(CONTEXT));
    ccr_alu_model u_alu (.clk(CLK), .result(ALU_RESULT), .carry(FLAG_CARRY_IN));
    task automatic check(input logic [11:0] got, input int exp, input string what);
        total_checks++;
        if (got !== 12'(exp))
        begin
            errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic summarize();
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    // advance the model by the inputs sampled at this edge
    task automatic step();
        if (DS_WR)
            m_reg[DS_ADDR] = DS_WDATA;
        if (FLAG_CARRY_WE)
            m_c[m_ctx] = FLAG_CARRY_IN;
        if (FLAG_ZERO_WE)
            m_z[m_ctx] = (ALU_RESULT == 8'h00);
        if (PC_SRC == 3'h1)
            m_pc = m_pc + 12'h001;
        else if (PC_SRC == 3'h2)
            m_pc = m_pc + {{4{REL_OFFSET[7]}}, REL_OFFSET};
        else if (PC_SRC == 3'h3)
            m_pc = PC_TARGET;
        else if (PC_SRC == 3'h7 && stk.size() == 0)
            m_pc = m_pc + 12'h001;
        else if (PC_SRC == 3'h7)
        begin
            m_pc = stk.pop_front();
            m_ctx = IRQ_EXIT ? m_saved : m_ctx;
            m_saved = IRQ_EXIT ? 1 : m_saved;
        end
        else if (PC_SRC != 3'h0)
        begin
            stk.push_front(m_pc);
            if (stk.size() > 6)
                void'(stk.pop_back());
            m_pc = (PC_SRC == 3'h4) ? PC_TARGET : (PC_SRC == 3'h5) ? IRQ_VECTOR : NMI_VECTOR;
            m_saved = (PC_SRC == 3'h4) ? m_saved : (m_ctx == 4) ? 1 : m_ctx;
            m_ctx = (PC_SRC == 3'h4) ? m_ctx : (PC_SRC == 3'h5) ? 2 : 4;
        end
    endtask : step
    // flag writes kept off context-switch cycles, where the outgoing pair is still the one open
    task automatic drive(input bit pops);
        int s;
        s = (pops && $urandom % 2) ? 7 : $urandom % 8;
        PC_SRC <= 3'(s);
        IRQ_EXIT <= s == 7 && stk.size() > 0 && $urandom % 2;
        PC_TARGET <= 12'($urandom);
        REL_OFFSET <= 8'($urandom);
        DS_ADDR <= ($urandom % 4 != 0) ? amap[$urandom % 5] : 8'($urandom);
        DS_WR <= 1'($urandom);
        DS_WDATA <= 8'($urandom);
        FLAG_CARRY_WE <= s < 5 && $urandom % 2;
        FLAG_ZERO_WE <= s < 5 && $urandom % 2;
    endtask : drive
    task automatic compare();
        bit hit;
        hit = DS_ADDR inside {amap};
        check(DS_HIT, hit, "hit");
        check(DS_RDATA, hit ? m_reg[DS_ADDR] : 0, "rdata");
        check(ACC, m_reg[255], "acc");
        check(PTR_FIRST, m_reg[128], "ptr1");
        check(PTR_SECOND, m_reg[129], "ptr2");
        check(PC, m_pc, "pc");
        check(STACK_EMPTY, stk.size() == 0, "empty");
        check(CONTEXT, m_ctx, "ctx");
        check(CARRY, m_c[m_ctx], "carry");
        check(ZERO, m_z[m_ctx], "zero");
    endtask : compare
    // hang guard, well above the planned run
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            errors++;
            summarize();
        end
    end
    // pushes dominate first to saturate, returns dominate later to underflow
    initial
    begin
        void'($urandom(32'h824402C7));
        repeat (8) @(posedge CLK);
        RST_B <= 1'b1;
        #1 compare();
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge CLK);
            step();
            drive(i >= 1500);
            #1 compare();
        end
        summarize();
    end
endmodule : cpu_context_regs_stack_tb
bind ccr_core_regs ccr_core_regs_props #(.IRQ_VECTOR(IRQ_VECTOR)) u_props (.CLK(CLK), .RST_B(RST_B),
    .DS_ADDR(DS_ADDR), .DS_WR(DS_WR), .DS_WDATA(DS_WDATA), .DS_RDATA(DS_RDATA), .DS_HIT(DS_HIT), .ACC(ACC),
    .PC_SRC(PC_SRC), .PC_TARGET(PC_TARGET), .PC(PC), .STACK_EMPTY(STACK_EMPTY), .FLAG_ZERO_WE(FLAG_ZERO_WE),
    .ALU_RESULT(ALU_RESULT), .ZERO(ZERO), .CONTEXT(CONTEXT));

// [logic/ccr_core_regs.sv]
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_core_regs
    import ccr_pkg::*;
#(
    parameter int AW = 12,
    parameter logic [11:0] RESET_VECTOR = `CCR_RESET_VECTOR,
    parameter logic [11:0] IRQ_VECTOR = `CCR_IRQ_VECTOR,
    parameter logic [11:0] NMI_VECTOR = `CCR_NMI_VECTOR
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // data space access
    input wire logic [7:0] DS_ADDR,
    input wire logic DS_WR,
    input wire logic [7:0] DS_WDATA,
    output logic [7:0] DS_RDATA,
    output logic DS_HIT,
    // pointer contents for indirect addressing, and the accumulator
    output logic [7:0] PTR_FIRST,
    output logic [7:0] PTR_SECOND,
    output logic [7:0] ACC,
    // program counter control
    input wire logic [2:0] PC_SRC,
    input wire logic [11:0] PC_TARGET,
    input wire logic [7:0] REL_OFFSET,
    output logic [11:0] PC,
    output logic STACK_EMPTY,
    // flag update from the alu
    input wire logic FLAG_CARRY_WE,
    input wire logic FLAG_CARRY_IN,
    input wire logic FLAG_ZERO_WE,
    input wire logic [7:0] ALU_RESULT,
    input wire logic IRQ_EXIT,
    output logic CARRY,
    output logic ZERO,
    output logic [2:0] CONTEXT
);

    logic [7:0] accumulator;
    logic [7:0] pointer_first;
    logic [7:0] pointer_second;
    logic [7:0] short_direct_first;
    logic [7:0] short_direct_second;
    logic [11:0] pc;
    logic [11:0] next_pc;
    // one flag pair per context
    logic carry_normal;
    logic zero_normal;
    logic carry_irq;
    logic zero_irq;
    logic carry_nonmask;
    logic zero_nonmask;
    ccr_ctx_t ctx;
    ccr_ctx_t saved_ctx;
    ccr_ctx_t next_ctx;
    ccr_ctx_t next_saved_ctx;
    logic [11:0] stack_top;
    logic stack_empty;

    // zero test shared by the three pair writers
    function automatic logic is_zero(input logic [7:0] value);
        return value == 8'h00;
    endfunction : is_zero

    // one program step; the sum wraps inside twelve bits
    function automatic logic [11:0] pc_step(input logic [11:0] value);
        return value + 12'h001;
    endfunction : pc_step

    // member of a flag triple {nonmask, irq, normal} for a context
    function automatic logic pick_flag(input ccr_ctx_t sel, input logic [2:0] triple);
        logic chosen;
        case (sel)
            CCR_CTX_NORMAL: chosen = triple[0];
            CCR_CTX_IRQ: chosen = triple[1];
            default: chosen = triple[2];
        endcase
        return chosen;
    endfunction : pick_flag

    // address decoding
    wire hit_acc = (DS_ADDR == `CCR_ADDR_ACC);
    wire hit_ptr1 = (DS_ADDR == `CCR_ADDR_PTR_FIRST);
    wire hit_ptr2 = (DS_ADDR == `CCR_ADDR_PTR_SECOND);
    wire hit_sd1 = (DS_ADDR == `CCR_ADDR_SD_FIRST);
    wire hit_sd2 = (DS_ADDR == `CCR_ADDR_SD_SECOND);

    // per-register write strobes
    wire wr_acc = DS_WR && hit_acc;
    wire wr_ptr1 = DS_WR && hit_ptr1;
    wire wr_ptr2 = DS_WR && hit_ptr2;
    wire wr_sd1 = DS_WR && hit_sd1;
    wire wr_sd2 = DS_WR && hit_sd2;

    // sequencer decode of the pc source
    ccr_pc_src_t src;
    assign src = ccr_pc_src_t'(PC_SRC);
    wire is_push = (src == CCR_PC_CALL) || (src == CCR_PC_IRQ) || (src == CCR_PC_NMI);
    wire is_pop = (src == CCR_PC_RET);
    wire ctx_entry = (src == CCR_PC_IRQ) || (src == CCR_PC_NMI);
    wire ctx_exit = IRQ_EXIT && is_pop;
    wire [11:0] rel_sum = pc + {{4{REL_OFFSET[7]}}, REL_OFFSET};

    // return target; an empty stack falls through to the next instruction
    wire [11:0] ret_pc = stack_empty ? pc_step(pc) : stack_top;

    // read mux; other addresses belong to ram, so no hit
    assign DS_HIT = hit_acc | hit_ptr1 | hit_ptr2 | hit_sd1 | hit_sd2;
    assign DS_RDATA = hit_acc ? accumulator :
                      hit_ptr1 ? pointer_first :
                      hit_ptr2 ? pointer_second :
                      hit_sd1 ? short_direct_first :
                      hit_sd2 ? short_direct_second : 8'h00;

    assign PTR_FIRST = pointer_first;
    assign PTR_SECOND = pointer_second;
    assign ACC = accumulator;
    assign PC = pc;
    assign STACK_EMPTY = stack_empty;
    assign CONTEXT = ctx;

    // active pair only is visible
    assign CARRY = pick_flag(ctx, {carry_nonmask, carry_irq, carry_normal});
    assign ZERO = pick_flag(ctx, {zero_nonmask, zero_irq, zero_normal});

    // data-space registers
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            accumulator <= `CCR_REG_RESET;
            pointer_first <= `CCR_REG_RESET;
            pointer_second <= `CCR_REG_RESET;
            short_direct_first <= `CCR_REG_RESET;
            short_direct_second <= `CCR_REG_RESET;
        end
        else
        begin
            if (wr_acc)
                accumulator <= DS_WDATA;
            if (wr_ptr1)
                pointer_first <= DS_WDATA;
            if (wr_ptr2)
                pointer_second <= DS_WDATA;
            if (wr_sd1)
                short_direct_first <= DS_WDATA;
            if (wr_sd2)
                short_direct_second <= DS_WDATA;
        end
    end

    // pc next value; empty-stack return falls through to pc+1
    always_comb
    begin
        case (src)
            CCR_PC_INC: next_pc = pc_step(pc);
            CCR_PC_REL: next_pc = rel_sum;
            CCR_PC_JUMP: next_pc = PC_TARGET;
            CCR_PC_CALL: next_pc = PC_TARGET;
            CCR_PC_IRQ: next_pc = IRQ_VECTOR;
            CCR_PC_NMI: next_pc = NMI_VECTOR;
            CCR_PC_RET: next_pc = ret_pc;
            default: next_pc = pc;
        endcase
    end

    // twelve-bit pc wraps within 4096 bytes
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            pc <= RESET_VECTOR;
        else
            pc <= next_pc;
    end

    // context: one level of history is enough for irq exit
    always_comb
    begin
        next_ctx = ctx;
        next_saved_ctx = saved_ctx;
        if (src == CCR_PC_NMI)
            next_ctx = CCR_CTX_NMI;
        else if (src == CCR_PC_IRQ)
            next_ctx = CCR_CTX_IRQ;
        // an irq exit on an empty stack still restores the context
        else if (ctx_exit)
            next_ctx = saved_ctx;
        // nested non-maskable entry cannot return to itself, so it records normal
        if (ctx_entry)
            next_saved_ctx = (ctx == CCR_CTX_NMI) ? CCR_CTX_NORMAL : ctx;
        else if (ctx_exit)
            next_saved_ctx = CCR_CTX_NORMAL;
    end

    // active context and its history
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctx <= CCR_CTX_NMI;
            saved_ctx <= CCR_CTX_NORMAL;
        end
        else
        begin
            ctx <= next_ctx;
            saved_ctx <= next_saved_ctx;
        end
    end

    // pair write strobes; a pair moves only while its own context runs
    wire carry_we_normal = FLAG_CARRY_WE && (ctx == CCR_CTX_NORMAL);
    wire carry_we_irq = FLAG_CARRY_WE && (ctx == CCR_CTX_IRQ);
    wire carry_we_nonmask = FLAG_CARRY_WE && (ctx == CCR_CTX_NMI);
    wire zero_we_normal = FLAG_ZERO_WE && (ctx == CCR_CTX_NORMAL);
    wire zero_we_irq = FLAG_ZERO_WE && (ctx == CCR_CTX_IRQ);
    wire zero_we_nonmask = FLAG_ZERO_WE && (ctx == CCR_CTX_NMI);
    wire alu_zero = is_zero(ALU_RESULT);

    // normal pair; never cleared on a switch, so values survive nesting
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            carry_normal <= `CCR_FLAG_RESET;
            zero_normal <= `CCR_FLAG_RESET;
        end
        else
        begin
            if (carry_we_normal)
                carry_normal <= FLAG_CARRY_IN;
            if (zero_we_normal)
                zero_normal <= alu_zero;
        end
    end

    // interrupt pair
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            carry_irq <= `CCR_FLAG_RESET;
            zero_irq <= `CCR_FLAG_RESET;
        end
        else
        begin
            if (carry_we_irq)
                carry_irq <= FLAG_CARRY_IN;
            if (zero_we_irq)
                zero_irq <= alu_zero;
        end
    end

    // non-maskable pair, the one in use straight out of reset
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            carry_nonmask <= `CCR_FLAG_RESET;
            zero_nonmask <= `CCR_FLAG_RESET;
        end
        else
        begin
            if (carry_we_nonmask)
                carry_nonmask <= FLAG_CARRY_IN;
            if (zero_we_nonmask)
                zero_nonmask <= alu_zero;
        end
    end

    // return address is the already-advanced pc
    // overflow and underflow are silent; nesting depth is the software's to bound
    ccr_ret_stack #(
        .DEPTH(`CCR_STACK_DEPTH),
        .AW(AW)
    ) u_stack (
        .clk(CLK),
        .rst_b(RST_B),
        .push(is_push),
        .pop(is_pop),
        .push_value(pc),
        .top(stack_top),
        .empty(stack_empty)
    );

endmodule : ccr_core_regs

// [logic/ccr_defs.svh]
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// data-space locations of the core registers
`define CCR_ADDR_PTR_FIRST 8'h80
`define CCR_ADDR_PTR_SECOND 8'h81
`define CCR_ADDR_SD_FIRST 8'h82
`define CCR_ADDR_SD_SECOND 8'h83
`define CCR_ADDR_ACC 8'hFF

// reset values (none documented, zero chosen) and the return stack depth
`define CCR_REG_RESET 8'h00
`define CCR_PC_RESET 12'h000
`define CCR_STACK_DEPTH 6
`define CCR_FLAG_RESET 1'b0

// vector defaults, arbitrary values
`define CCR_RESET_VECTOR 12'hFFE
`define CCR_IRQ_VECTOR 12'hFF0
`define CCR_NMI_VECTOR 12'hFFC

`endif

// [logic/ccr_pkg.sv]
package ccr_pkg;

    // flag context, one-hot
    typedef enum logic [2:0]
    {
        CCR_CTX_NORMAL = 3'h1,
        CCR_CTX_IRQ = 3'h2,
        CCR_CTX_NMI = 3'h4
    } ccr_ctx_t;

    // program counter source selected by the sequencer
    typedef enum logic [2:0]
    {
        CCR_PC_HOLD = 3'h0,
        CCR_PC_INC = 3'h1,
        CCR_PC_REL = 3'h2,
        CCR_PC_JUMP = 3'h3,
        CCR_PC_CALL = 3'h4,
        CCR_PC_IRQ = 3'h5,
        CCR_PC_NMI = 3'h6,
        CCR_PC_RET = 3'h7
    } ccr_pc_src_t;

endpackage : ccr_pkg

// [logic/ccr_ret_stack.sv]
`timescale 1ns/1ps
`include "ccr_defs.svh"

// six-level shift stack, no pointer
module ccr_ret_stack
    import ccr_pkg::*;
#(
    parameter int DEPTH = `CCR_STACK_DEPTH,
    parameter int AW = 12
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic push,
    input wire logic pop,
    input wire logic [AW-1:0] push_value,
    // state
    output logic [AW-1:0] top,
    output logic empty
);

    logic [AW-1:0] level [DEPTH];
    logic [DEPTH-1:0] used;

    assign top = level[0];
    assign empty = ~used[0];

    // shift whole array; deepest level falls off on overflow
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < DEPTH; i++)
                level[i] <= '0;
            used <= '0;
        end
        else if (push)
        begin
            level[0] <= push_value;
            for (int i = 1; i < DEPTH; i++)
                level[i] <= level[i-1];
            used <= {used[DEPTH-2:0], 1'b1};
        end
        else if (pop && used[0])
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                level[i] <= level[i+1];
            used <= {1'b0, used[DEPTH-1:1]};
        end
        // pop on empty stack: nothing moves
    end

endmodule : ccr_ret_stack
